// ### fpuio_pkg.sv
package fpuio_pkg;
	// ----------------------------------------
	// port width codes
	// ----------------------------------------
	localparam logic [1:0] WID_BYTE = 2'h0;
	localparam logic [1:0] WID_WORD = 2'h1;
	localparam logic [1:0] WID_LONG = 2'h2;
	// ----------------------------------------
	// status word bit positions
	// ----------------------------------------
	localparam int ST_NOACC = 0;
	localparam int ST_SEQ = 1;
	localparam int ST_DIR = 2;
	// ----------------------------------------
	// system configuration word fields
	// ----------------------------------------
	localparam int CFG_VEC = 0;
	localparam int CFG_EXC = 8;
	localparam int CFG_WID = 16;
	localparam int CFG_OVL = 18;
	localparam logic [1:0] OVL_MAX = 2'h3;
	// ----------------------------------------
	// host controller register map and fields
	// ----------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TXD = 8'h04;
	localparam logic [7:0] A_RXD = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_ISTAT = 8'h10;
	localparam logic [7:0] A_IMASK = 8'h14;
	localparam int C_CMD = 0;
	localparam int C_GO = 2;
	localparam int C_WID = 4;
	localparam logic [1:0] CMD_WR = 2'h0;
	localparam logic [1:0] CMD_RD = 2'h1;
	localparam logic [1:0] CMD_STAT = 2'h2;
	localparam logic [1:0] CMD_VEC = 2'h3;
	localparam int I_DONE = 0;
	localparam int I_IRQ = 1;
	// ----------------------------------------
	// host cycle timing, clk_sys cycles
	// ----------------------------------------
	localparam logic [3:0] STROBE_MIN = 4'h8;
	localparam logic [3:0] GAP_MIN = 4'h3;

	// bits carried per bus cycle
	function automatic logic [5:0] wbits(input logic [1:0] c);
		wbits = (c == WID_BYTE) ? 6'h08 : (c == WID_WORD) ? 6'h10 : 6'h20;
	endfunction : wbits

	// bus cycles per 32-bit unit
	function automatic logic [2:0] nbeats(input logic [1:0] c);
		nbeats = (c == WID_BYTE) ? 3'h4 : (c == WID_WORD) ? 3'h2 : 3'h1;
	endfunction : nbeats

	// low lanes used at a given width
	function automatic logic [31:0] lmask(input logic [5:0] w);
		lmask = (w == 6'h20) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
	endfunction : lmask
endpackage : fpuio_pkg

// ### fpuio_if.sv
`timescale 1ns/1ns
`default_nettype none
interface fpuio_if;
	logic ce_n;
	logic rd_n;
	logic wr_n;
	logic stat_sel;
	logic vec_fetch_n;
	logic [31:0] host_d;
	logic host_d_oe_n;
	logic [31:0] dev_d;
	logic dev_d_oe_n;
	logic no_accept_n;
	logic seq_active_n;
	logic stall_o;
	logic stall_oe_n;
	logic int_req_n;
	logic [31:0] d_bus;
	logic stall_n;

	// ----------------------------------------
	// wire resolution
	// ----------------------------------------
	// data bus: whoever enables drives; stall is pulled up
	assign d_bus = !dev_d_oe_n ? dev_d : (!host_d_oe_n ? host_d : 32'h00000000);
	assign stall_n = stall_oe_n ? 1'b1 : stall_o;

	modport device(input ce_n, rd_n, wr_n, stat_sel, vec_fetch_n, d_bus,
		output dev_d, dev_d_oe_n, no_accept_n, seq_active_n, stall_o, stall_oe_n, int_req_n);
	modport host(input d_bus, stall_n, no_accept_n, seq_active_n, int_req_n,
		output ce_n, rd_n, wr_n, stat_sel, vec_fetch_n, host_d, host_d_oe_n);
endinterface : fpuio_if
`default_nettype wire

// ### fpuio_device.sv
`timescale 1ns/1ns
`default_nettype none
module fpuio_device import fpuio_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	fpuio_if.device bus,
	input wire logic [31:0] cfg_word,
	input wire logic core_busy,
	input wire logic core_exec,
	input wire logic core_need_operand,
	input wire logic core_have_result,
	input wire logic core_seq_done,
	input wire logic [31:0] result_word,
	input wire logic [7:0] core_exception,
	output logic [31:0] instr_word,
	output logic instr_valid,
	output logic [31:0] operand_word,
	output logic operand_valid,
	output logic result_taken,
	output logic flush,
	output logic [31:0] exception_pc_first,
	output logic [31:0] exception_pc_second
);
	typedef enum logic [2:0] {FS_IDLE, FS_INSTR, FS_DECIDE, FS_OPND, FS_RSLT} fpuio_dstate_t;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [36:0] pin_meta_reg;
	logic [36:0] pin_sync_reg;
	// two flops on every host pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_reg <= 37'h01D00000000;
			pin_sync_reg <= 37'h01D00000000;
		end else begin
			pin_meta_reg <= {bus.ce_n, bus.rd_n, bus.wr_n, bus.stat_sel, bus.vec_fetch_n, bus.d_bus};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	logic ce, rd, wr, ssel, vec;
	logic [31:0] din;
	logic stat_rd, vec_rd, norm;
	// decode of the synchronised cycle
	always_comb begin
		ce = !pin_sync_reg[36];
		rd = !pin_sync_reg[35];
		wr = !pin_sync_reg[34];
		ssel = pin_sync_reg[33];
		vec = !pin_sync_reg[32];
		din = pin_sync_reg[31:0];
		stat_rd = ce && rd && ssel;
		vec_rd = vec && rd;
		norm = ce && (rd || wr) && !ssel && !vec;
	end

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	fpuio_dstate_t state_reg, state_next;
	logic [2:0] beat_reg, beat_next;
	logic [31:0] asm_reg, asm_next;
	logic [31:0] out_reg, out_next;
	logic done_reg, done_next;
	logic [31:0] dout_reg, dout_next;
	logic doe_n_reg, doe_n_next;
	logic stall_oe_n_reg, stall_oe_n_next;
	logic irq_reg, irq_next;
	logic vown_reg, vown_next;
	logic noacc_n_reg, noacc_n_next;
	logic seq_n_reg, seq_n_next;
	logic [31:0] instr_reg, instr_next;
	logic ivld_reg, ivld_next;
	logic [31:0] opnd_reg, opnd_next;
	logic ovld_reg, ovld_next;
	logic rtak_reg, rtak_next;
	logic flush_reg, flush_next;
	logic [5:0] w;
	logic [2:0] nb;
	logic busy, exc, irq_hit, last;
	logic [2:0] status;
	logic [31:0] shifted;

	// next-state of the engine, pins and user strobes
	always_comb begin
		w = wbits(cfg_word[CFG_WID +: 2]);
		nb = nbeats(cfg_word[CFG_WID +: 2]);
		last = ((beat_reg + 3'h1) == nb);
		shifted = (asm_reg << w) | (din & lmask(w));
		// one instruction at a time unless maximum overlap
		busy = core_busy || (state_reg == FS_DECIDE)
			|| ((state_reg == FS_IDLE) && core_exec && (cfg_word[CFG_OVL +: 2] != OVL_MAX));
		status = 3'h0;
		status[ST_NOACC] = busy;
		status[ST_SEQ] = (state_reg != FS_IDLE);
		status[ST_DIR] = (state_reg == FS_RSLT);
		exc = |core_exception;
		irq_hit = |(core_exception & cfg_word[CFG_EXC +: 8]);
		state_next = state_reg;
		beat_next = beat_reg;
		asm_next = asm_reg;
		out_next = out_reg;
		done_next = done_reg && norm;
		dout_next = dout_reg;
		instr_next = instr_reg;
		opnd_next = opnd_reg;
		ivld_next = 1'b0;
		ovld_next = 1'b0;
		rtak_next = 1'b0;
		flush_next = 1'b0;
		// vector ownership held for the whole acknowledge read
		vown_next = vec_rd && (irq_reg || vown_reg);
		irq_next = irq_hit || (irq_reg && !(vown_reg && !vec_rd));
		if (stat_rd) begin
			dout_next = {29'h0, status};
		end else if (vec_rd) begin
			dout_next = {24'h0, cfg_word[CFG_VEC +: 8]};
		end
		if (exc) begin
			// drop every queued or partly sent instruction
			state_next = FS_IDLE;
			beat_next = 3'h0;
			asm_next = 32'h0;
			flush_next = 1'b1;
			done_next = norm;
		end else if (norm && !done_reg && !busy) begin
			done_next = 1'b1;
			case (state_reg)
				FS_IDLE, FS_INSTR: begin
					if (wr) begin
						asm_next = shifted;
						beat_next = beat_reg + 3'h1;
						state_next = FS_INSTR;
						if (last) begin
							instr_next = shifted;
							ivld_next = 1'b1;
							beat_next = 3'h0;
							asm_next = 32'h0;
							state_next = FS_DECIDE;
						end
					end else begin
						dout_next = 32'h0;
					end
				end
				FS_OPND: begin
					if (wr) begin
						asm_next = shifted;
						beat_next = beat_reg + 3'h1;
						if (last) begin
							opnd_next = shifted;
							ovld_next = 1'b1;
							beat_next = 3'h0;
							asm_next = 32'h0;
							state_next = FS_DECIDE;
						end
					end else begin
						dout_next = 32'h0;
					end
				end
				FS_RSLT: begin
					// a write here is lost; a read takes the top part
					if (rd) begin
						dout_next = out_reg >> (6'h20 - w);
						out_next = out_reg << w;
						beat_next = beat_reg + 3'h1;
						if (last) begin
							beat_next = 3'h0;
							state_next = FS_DECIDE;
						end
					end
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end else if (state_reg == FS_DECIDE && !core_busy) begin
			if (core_need_operand) begin
				state_next = FS_OPND;
			end else if (core_have_result) begin
				out_next = result_word;
				rtak_next = 1'b1;
				state_next = FS_RSLT;
			end else if (core_seq_done) begin
				state_next = FS_IDLE;
			end
		end
		// drive data only for reads this end owns
		doe_n_next = !((stat_rd) || (vec_rd && vown_next) || (norm && rd));
		stall_oe_n_next = !(norm && !done_next);
		noacc_n_next = !busy;
		seq_n_next = (state_next == FS_IDLE);
	end

	// engine registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= FS_IDLE;
			beat_reg <= 3'h0;
			asm_reg <= 32'h0;
			out_reg <= 32'h0;
			done_reg <= 1'b0;
			dout_reg <= 32'h0;
			doe_n_reg <= 1'b1;
			stall_oe_n_reg <= 1'b1;
			irq_reg <= 1'b0;
			vown_reg <= 1'b0;
			noacc_n_reg <= 1'b1;
			seq_n_reg <= 1'b1;
			instr_reg <= 32'h0;
			ivld_reg <= 1'b0;
			opnd_reg <= 32'h0;
			ovld_reg <= 1'b0;
			rtak_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			beat_reg <= beat_next;
			asm_reg <= asm_next;
			out_reg <= out_next;
			done_reg <= done_next;
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
			stall_oe_n_reg <= stall_oe_n_next;
			irq_reg <= irq_next;
			vown_reg <= vown_next;
			noacc_n_reg <= noacc_n_next;
			seq_n_reg <= seq_n_next;
			instr_reg <= instr_next;
			ivld_reg <= ivld_next;
			opnd_reg <= opnd_next;
			ovld_reg <= ovld_next;
			rtak_reg <= rtak_next;
			flush_reg <= flush_next;
		end
	end

	// ----------------------------------------
	// pins and user outputs
	// ----------------------------------------
	assign bus.dev_d = dout_reg;
	assign bus.dev_d_oe_n = doe_n_reg;
	assign bus.no_accept_n = noacc_n_reg;
	assign bus.seq_active_n = seq_n_reg;
	assign bus.stall_o = 1'b0;
	assign bus.stall_oe_n = stall_oe_n_reg;
	assign bus.int_req_n = !irq_reg;
	assign instr_word = instr_reg;
	assign instr_valid = ivld_reg;
	assign operand_word = opnd_reg;
	assign operand_valid = ovld_reg;
	assign result_taken = rtak_reg;
	assign flush = flush_reg;

	// addresses never seen, so saved counters stay empty
	logic [31:0] pc_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pc_reg <= 32'h0;
		end else begin
			pc_reg <= 32'h0;
		end
	end
	assign exception_pc_first = pc_reg;
	assign exception_pc_second = pc_reg;
endmodule : fpuio_device
`default_nettype wire

// ### fpuio_host.sv
`timescale 1ns/1ns
`default_nettype none
module fpuio_host import fpuio_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	fpuio_if.host bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_WAIT, HS_GAP} fpuio_hstate_t;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [35:0] meta_reg;
	logic [35:0] sync_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= 36'hF00000000;
			sync_reg <= 36'hF00000000;
		end else begin
			meta_reg <= {bus.stall_n, bus.no_accept_n, bus.seq_active_n, bus.int_req_n, bus.d_bus};
			sync_reg <= meta_reg;
		end
	end

	// ----------------------------------------
	// cycle engine and registers
	// ----------------------------------------
	fpuio_hstate_t hs_reg, hs_next;
	logic [1:0] cmd_reg, cmd_next;
	logic [1:0] wid_reg, wid_next;
	logic [2:0] beat_reg, beat_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [31:0] tx_reg, tx_next;
	logic [31:0] rx_reg, rx_next;
	logic ce_n_reg, ce_n_next, rd_n_reg, rd_n_next, wr_n_reg, wr_n_next;
	logic ssel_reg, ssel_next, vec_n_reg, vec_n_next;
	logic [31:0] hd_reg, hd_next;
	logic hoe_n_reg, hoe_n_next;
	logic [1:0] ist_reg, ist_next, imask_reg, imask_next;
	logic irqd_reg, irqd_next;
	logic [31:0] prd_reg, prd_next;
	logic prdy_reg, prdy_next, perr_reg, perr_next, irq_reg, irq_next;
	logic [5:0] w;
	logic fire, go, mapped, irq_rise;
	logic [1:0] ev;

	always_comb begin
		w = wbits(wid_reg);
		fire = psel && penable && prdy_reg;
		mapped = (paddr == A_CTRL) || (paddr == A_TXD) || (paddr == A_RXD)
			|| (paddr == A_STAT) || (paddr == A_ISTAT) || (paddr == A_IMASK);
		go = fire && pwrite && (paddr == A_CTRL) && pwdata[C_GO] && (hs_reg == HS_IDLE);
		irq_rise = !sync_reg[32] && irqd_reg;
		irqd_next = sync_reg[32];
		hs_next = hs_reg;
		cmd_next = cmd_reg;
		wid_next = wid_reg;
		beat_next = beat_reg;
		cnt_next = cnt_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		ce_n_next = ce_n_reg;
		rd_n_next = rd_n_reg;
		wr_n_next = wr_n_reg;
		ssel_next = ssel_reg;
		vec_n_next = vec_n_reg;
		hd_next = hd_reg;
		hoe_n_next = hoe_n_reg;
		ev = 2'h0;
		ev[I_IRQ] = irq_rise;
		imask_next = imask_reg;
		if (fire && pwrite && (paddr == A_TXD)) begin
			tx_next = pwdata;
		end
		if (fire && pwrite && (paddr == A_IMASK)) begin
			imask_next = pwdata[1:0];
		end
		case (hs_reg)
			HS_IDLE: begin
				if (go) begin
					cmd_next = pwdata[C_CMD +: 2];
					wid_next = pwdata[C_WID +: 2];
					beat_next = 3'h0;
					rx_next = 32'h0;
					hs_next = HS_SETUP;
				end
			end
			HS_SETUP: begin
				// enable, select and data settle before the strobe
				ce_n_next = (cmd_reg == CMD_VEC);
				ssel_next = (cmd_reg == CMD_STAT);
				vec_n_next = (cmd_reg != CMD_VEC);
				hd_next = (tx_reg >> (6'h20 - w)) & lmask(w);
				hoe_n_next = (cmd_reg != CMD_WR);
				cnt_next = 4'h0;
				hs_next = HS_STROBE;
			end
			HS_STROBE: begin
				rd_n_next = (cmd_reg == CMD_WR);
				wr_n_next = (cmd_reg != CMD_WR);
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == STROBE_MIN) begin
					hs_next = HS_WAIT;
				end
			end
			HS_WAIT: begin
				// device stall released: the cycle may end
				if (sync_reg[35]) begin
					if (cmd_reg == CMD_RD) begin
						rx_next = (rx_reg << w) | (sync_reg[31:0] & lmask(w));
					end else if (cmd_reg != CMD_WR) begin
						rx_next = sync_reg[31:0];
					end
					tx_next = tx_reg << w;
					ce_n_next = 1'b1;
					rd_n_next = 1'b1;
					wr_n_next = 1'b1;
					vec_n_next = 1'b1;
					hoe_n_next = 1'b1;
					beat_next = beat_reg + 3'h1;
					cnt_next = 4'h0;
					hs_next = HS_GAP;
				end
			end
			HS_GAP: begin
				cnt_next = cnt_reg + 4'h1;
				if (cnt_reg == GAP_MIN) begin
					ssel_next = 1'b0;
					if ((cmd_reg == CMD_RD || cmd_reg == CMD_WR) && beat_reg != nbeats(wid_reg)) begin
						hs_next = HS_SETUP;
					end else begin
						ev[I_DONE] = 1'b1;
						hs_next = HS_IDLE;
					end
				end
			end
			default: begin
				hs_next = HS_IDLE;
			end
		endcase
		// set wins over a one-written clear
		ist_next = ev | (ist_reg & ~((fire && pwrite && paddr == A_ISTAT) ? pwdata[1:0] : 2'h0));
		irq_next = |(ist_next & imask_next);
		prdy_next = psel && penable && !prdy_reg;
		perr_next = psel && penable && !prdy_reg && !mapped;
		prd_next = 32'h0;
		if (psel && penable && !prdy_reg && !pwrite) begin
			case (paddr)
				A_CTRL: prd_next = {26'h0, wid_reg, 2'h0, cmd_reg};
				A_TXD: prd_next = tx_reg;
				A_RXD: prd_next = rx_reg;
				A_STAT: prd_next = {28'h0, !sync_reg[32], !sync_reg[33], !sync_reg[34], hs_reg != HS_IDLE};
				A_ISTAT: prd_next = {30'h0, ist_reg};
				A_IMASK: prd_next = {30'h0, imask_reg};
				default: prd_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hs_reg <= HS_IDLE;
			cmd_reg <= CMD_WR;
			wid_reg <= WID_BYTE;
			beat_reg <= 3'h0;
			cnt_reg <= 4'h0;
			tx_reg <= 32'h0;
			rx_reg <= 32'h0;
			ce_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			ssel_reg <= 1'b0;
			vec_n_reg <= 1'b1;
			hd_reg <= 32'h0;
			hoe_n_reg <= 1'b1;
			ist_reg <= 2'h0;
			imask_reg <= 2'h0;
			irqd_reg <= 1'b1;
			prd_reg <= 32'h0;
			prdy_reg <= 1'b0;
			perr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			hs_reg <= hs_next;
			cmd_reg <= cmd_next;
			wid_reg <= wid_next;
			beat_reg <= beat_next;
			cnt_reg <= cnt_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			ce_n_reg <= ce_n_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			ssel_reg <= ssel_next;
			vec_n_reg <= vec_n_next;
			hd_reg <= hd_next;
			hoe_n_reg <= hoe_n_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			irqd_reg <= irqd_next;
			prd_reg <= prd_next;
			prdy_reg <= prdy_next;
			perr_reg <= perr_next;
			irq_reg <= irq_next;
		end
	end

	assign bus.ce_n = ce_n_reg;
	assign bus.rd_n = rd_n_reg;
	assign bus.wr_n = wr_n_reg;
	assign bus.stat_sel = ssel_reg;
	assign bus.vec_fetch_n = vec_n_reg;
	assign bus.host_d = hd_reg;
	assign bus.host_d_oe_n = hoe_n_reg;
	assign prdata = prd_reg;
	assign pready = prdy_reg;
	assign pslverr = perr_reg;
	assign irq = irq_reg;
endmodule : fpuio_host
`default_nettype wire

// ### fpuio_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fpuio_sva (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic stat_sel,
	input wire logic vec_fetch_n,
	input wire logic host_d_oe_n,
	input wire logic [31:0] dev_d,
	input wire logic dev_d_oe_n,
	input wire logic no_accept_n,
	input wire logic seq_active_n,
	input wire logic stall_oe_n,
	input wire logic int_req_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// ----------------------------------------
	// link checks
	// ----------------------------------------
	// status strobe seen on the pins
	wire stat_rd = !ce_n && !rd_n && stat_sel;

	AST_BUS_ONE_DRIVER: assert property (!(!dev_d_oe_n && !host_d_oe_n))
		else $error("both ends drive the data bus");
	AST_DEV_DRIVES_ON_READ: assert property (!dev_d_oe_n |-> !rd_n || !$past(rd_n, 1) || !$past(rd_n, 2)
		|| !$past(rd_n, 3) || !$past(rd_n, 4)) else $error("device drives bus with no read");
	AST_STALL_NORMAL_ONLY: assert property (!stall_oe_n |-> !ce_n && !stat_sel && vec_fetch_n)
		else $error("stall outside a normal access");
	AST_STATUS_BITS: assert property (stat_rd [*5] |-> !dev_d_oe_n && dev_d[0] == !no_accept_n
		&& dev_d[1] == !seq_active_n) else $error("status bits differ from pins");
	AST_STALL_BOUNDED: assert property ($fell(stall_oe_n) |-> ##[1:300] stall_oe_n)
		else $error("stall never released");
	AST_VEC_DRIVEN: assert property ((!vec_fetch_n && !rd_n && !int_req_n) [*5] |-> !dev_d_oe_n)
		else $error("vector not driven on acknowledge");
	AST_INT_CLEARED: assert property ($rose(rd_n) && !$past(vec_fetch_n) && !$past(int_req_n)
		|-> ##[1:8] int_req_n) else $error("request kept after acknowledge");
	AST_SETUP_BEFORE_STROBE: assert property (($fell(rd_n) || $fell(wr_n)) |-> !$past(ce_n)
		|| !$past(vec_fetch_n)) else $error("strobe without setup cycle");
	AST_SEL_STABLE: assert property (!ce_n && !$past(ce_n) |-> $stable(stat_sel))
		else $error("select moved inside access");
	AST_SEQ_ON_WRITE: assert property ($fell(wr_n) && seq_active_n && no_accept_n
		|-> ##[1:20] !seq_active_n) else $error("sequence flag not raised by write");
endmodule : fpuio_sva
`default_nettype wire

// ### fpu_io_port_status_interface_test.sv
`timescale 1ns/1ns
`default_nettype none
module fpu_io_port_status_interface_test import fpuio_pkg::*;;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr;
	logic [7:0] core_exception;
	logic [31:0] pwdata, prdata, cfg_word, result_word, instr_word, last_instr, rdv;
	logic core_busy, res_pend, result_taken, instr_valid, flush, errv, saw_stall, saw_flush;
	logic core_exec, core_need_operand, operand_valid;
	logic [31:0] operand_word, last_opnd, pc_first, pc_second;
	logic [31:0] wq[$];
	int mismatches, comparisons;
	wire core_have_result = res_pend & ~result_taken;

	fpuio_if fpuio_if_inst();
	fpuio_host fpuio_host_inst(.clk_sys(clk_sys), .rst_n(rst_n), .bus(fpuio_if_inst.host), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	fpuio_device fpuio_device_inst(.clk_sys(clk_sys), .rst_n(rst_n), .bus(fpuio_if_inst.device),
		.cfg_word(cfg_word), .core_busy(core_busy), .core_exec(core_exec), .core_need_operand(core_need_operand),
		.core_have_result(core_have_result), .core_seq_done(1'b1), .result_word(result_word),
		.core_exception(core_exception), .instr_word(instr_word), .instr_valid(instr_valid),
		.operand_word(operand_word), .operand_valid(operand_valid), .result_taken(result_taken), .flush(flush),
		.exception_pc_first(pc_first), .exception_pc_second(pc_second));
	fpuio_sva fpuio_sva_inst(.clk_sys(clk_sys), .rst_n(rst_n), .ce_n(fpuio_if_inst.ce_n),
		.rd_n(fpuio_if_inst.rd_n), .wr_n(fpuio_if_inst.wr_n), .stat_sel(fpuio_if_inst.stat_sel),
		.vec_fetch_n(fpuio_if_inst.vec_fetch_n), .host_d_oe_n(fpuio_if_inst.host_d_oe_n),
		.dev_d(fpuio_if_inst.dev_d), .dev_d_oe_n(fpuio_if_inst.dev_d_oe_n),
		.no_accept_n(fpuio_if_inst.no_accept_n), .seq_active_n(fpuio_if_inst.seq_active_n),
		.stall_oe_n(fpuio_if_inst.stall_oe_n), .int_req_n(fpuio_if_inst.int_req_n));

	// 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// monitors: last instruction, flush, stall and result hand-off
	always @(posedge clk_sys) begin
		if (instr_valid === 1'b1) last_instr <= instr_word;
		if (operand_valid === 1'b1) last_opnd <= operand_word;
		if (flush === 1'b1) saw_flush <= 1'b1;
		if (fpuio_if_inst.stall_n === 1'b0) saw_stall <= 1'b1;
		if (result_taken === 1'b1) res_pend <= 1'b0;
	end

	// record each write beat as it appears on the wire
	always @(negedge fpuio_if_inst.wr_n) wq.push_back(fpuio_if_inst.d_bus);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	// one APB transfer; pready, prdata and pslverr are taken at the edge that completes it
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// run one link operation and fetch its received word
	task op(input logic [1:0] cmd, input logic [1:0] w, input logic [31:0] d);
		int k;
		apb(1'b1, A_ISTAT, 32'h00000001);
		apb(1'b1, A_TXD, d);
		apb(1'b1, A_CTRL, {26'h0, w, 1'b0, 1'b1, cmd});
		k = 0;
		do begin
			apb(1'b0, A_ISTAT, 32'h00000000);
			k++;
		end while (rdv[I_DONE] !== 1'b1 && k < 400);
		chk({31'h0, rdv[I_DONE]}, 32'h00000001);
		apb(1'b1, A_ISTAT, 32'h00000001);
		apb(1'b0, A_RXD, 32'h00000000);
	endtask : op

	task setcfg(input logic [1:0] w);
		cfg_word <= {12'h0, 2'h0, w, 8'h01, 8'h5A};
	endtask : setcfg

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_status;
		setcfg(WID_BYTE);
		op(CMD_STAT, WID_BYTE, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000000);
		core_busy <= 1'b1;
		op(CMD_STAT, WID_BYTE, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000001);
		op(CMD_STAT, WID_BYTE, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000001);
		core_busy <= 1'b0;
		core_exec <= 1'b1;
		op(CMD_STAT, WID_BYTE, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000001);
		cfg_word[CFG_OVL +: 2] <= OVL_MAX;
		op(CMD_STAT, WID_BYTE, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000000);
		core_exec <= 1'b0;
		$display("status test done");
	endtask : t_status

	task t_writes;
		logic [31:0] v, m;
		int n, b;
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 32'h1234ABCD : (i == 1) ? 32'h8001FFFE : 32'hC3A55A3C;
			n = 4 >> i;
			b = 8 << i;
			m = (i == 2) ? 32'hFFFFFFFF : ((32'h1 << b) - 32'h1);
			setcfg(i[1:0]);
			wq.delete();
			op(CMD_WR, i[1:0], v);
			chk(last_instr, v);
			chk(32'(wq.size()), 32'(n));
			for (int j = 0; j < n; j++) chk(wq[j] & m, (v >> (b * (n - 1 - j))) & m);
		end
		$display("write test done");
	endtask : t_writes

	task t_read;
		setcfg(WID_WORD);
		core_need_operand <= 1'b1;
		op(CMD_WR, WID_WORD, 32'h13572468);
		core_need_operand <= 1'b0;
		op(CMD_STAT, WID_WORD, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000002);
		op(CMD_WR, WID_WORD, 32'h9ABC0DEF);
		chk(last_opnd, 32'h9ABC0DEF);
		chk(last_instr, 32'h13572468);
		result_word <= 32'hCAFE0123;
		res_pend <= 1'b1;
		op(CMD_WR, WID_WORD, 32'h00AA0055);
		op(CMD_STAT, WID_WORD, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000006);
		op(CMD_RD, WID_WORD, 32'h00000000);
		chk(rdv, 32'hCAFE0123);
		op(CMD_STAT, WID_WORD, 32'h00000000);
		chk({29'h0, rdv[2:0]}, 32'h00000000);
		$display("read test done");
	endtask : t_read

	task t_stall;
		setcfg(WID_LONG);
		saw_stall <= 1'b0;
		core_busy <= 1'b1;
		fork
			begin
				repeat (80) @(posedge clk_sys);
				core_busy <= 1'b0;
			end
		join_none
		op(CMD_WR, WID_LONG, 32'h0F1E2D3C);
		chk({31'h0, saw_stall}, 32'h00000001);
		chk(last_instr, 32'h0F1E2D3C);
		$display("stall test done");
	endtask : t_stall

	task t_irq;
		setcfg(WID_LONG);
		saw_flush <= 1'b0;
		apb(1'b1, A_IMASK, 32'h00000002);
		core_busy <= 1'b1;
		// exception lands while a stalled write waits, then the core frees up
		fork
			begin
				repeat (40) @(posedge clk_sys);
				core_exception <= 8'h01;
				@(posedge clk_sys);
				core_exception <= 8'h00;
				repeat (10) @(posedge clk_sys);
				core_busy <= 1'b0;
			end
		join_none
		op(CMD_WR, WID_LONG, 32'h55AA33CC);
		@(negedge clk_sys);
		chk(last_instr, 32'h0F1E2D3C);
		chk({31'h0, saw_flush}, 32'h00000001);
		chk(pc_first | pc_second, 32'h00000000);
		chk({31'h0, fpuio_if_inst.int_req_n}, 32'h00000000);
		chk({31'h0, irq}, 32'h00000001);
		// software sends the discarded instruction again
		op(CMD_WR, WID_LONG, 32'h55AA33CC);
		chk(last_instr, 32'h55AA33CC);
		apb(1'b1, A_IMASK, 32'h00000000);
		apb(1'b0, A_ISTAT, 32'h00000000);
		chk({31'h0, rdv[I_IRQ]}, 32'h00000001);
		@(negedge clk_sys);
		chk({31'h0, irq}, 32'h00000000);
		apb(1'b1, A_IMASK, 32'h00000002);
		op(CMD_VEC, WID_BYTE, 32'h00000000);
		chk({24'h0, rdv[7:0]}, 32'h0000005A);
		chk({31'h0, fpuio_if_inst.int_req_n}, 32'h00000001);
		apb(1'b1, A_ISTAT, 32'h00000002);
		@(negedge clk_sys);
		chk({31'h0, irq}, 32'h00000000);
		apb(1'b0, 8'h40, 32'h00000000);
		chk({31'h0, errv}, 32'h00000001);
		$display("interrupt test done");
	endtask : t_irq

	// main sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		cfg_word = 32'h00000000;
		result_word = 32'h00000000;
		core_exception = 8'h00;
		core_busy = 1'b0;
		core_exec = 1'b0;
		core_need_operand = 1'b0;
		res_pend = 1'b0;
		saw_stall = 1'b0;
		saw_flush = 1'b0;
		mismatches = 0;
		comparisons = 0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_status;
		t_writes;
		t_read;
		t_stall;
		t_irq;
		finish_test;
	end

	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge clk_sys);
		mismatches++;
		finish_test;
	end
endmodule : fpu_io_port_status_interface_test
`default_nettype wire
